// ---- logic/capture_compare_timer_pwm.sv ----
// Purpose: 16-bit timer with two captures, two compares, one-pulse and PWM
// Assumes: APB slave, zero wait states, 8-bit registers in low data bits
// Notes:   Pins pass two flip-flops before any logic reads them
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
// Operation
// - PWM mode uses compare 1 and compare 2 value; both are taken over.
// - PWM drives pin 1 to level one on match 1, level two on match 2.
// - PWM compare 2 match reloads counter with the start value.
// - High byte write inhibits that compare until low byte is written.
// - PWM mode never sets either compare flag.
// - PWM compare 2 match sets capture flag 1.
// - PWM disconnects capture pin 1; capture pin 2 still captures.
// - One-pulse and PWM both set means PWM only.
// - Capture interrupt enable raises interrupt for either capture flag.
// - Compare interrupt enable raises interrupt for either compare flag.
// - Overflow interrupt enable raises interrupt for overflow flag.
// - Writing force bit copies its level bit to its pin at once; ignored in one-pulse and PWM.
// - Match copies level bits to pins; one-pulse and PWM use level two.
// - Capture edge select: 0 falling, 1 rising.
// - External clock edge select: 0 falling, 1 rising.
// - Output enable bits hand the pins to the compare logic.
// - One-pulse: capture pin 1 edge starts a pulse ended by compare 1.
// - Clock select 00 div 4, 01 div 2, 10 div 8, 11 external.
// - Capture flags clear on status read then capture low byte access.
// - Compare flags clear on status read then compare low byte access.
// - Overflow flag set on rollover; cleared via counter low byte only.
// - Compare values reset to 8000h.
// - Writing the counter low byte resets the counter.
module capture_compare_timer_pwm (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        arst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Timer pins
   input  wire logic        extClockPin,
   input  wire logic        capturePinOne,
   input  wire logic        capturePinTwo,
   output logic             outputPinOne,
   output logic             outputEnableOne,
   output logic             outputPinTwo,
   output logic             outputEnableTwo,
   // Interrupt request
   output logic             timerIrq
);
   import timer_pkg::*;

   logic [7:0]  ctl1_ff;
   logic [7:0]  ctl2_ff;
   logic [15:0] cnt_ff;
   logic [15:0] cmp1_ff;
   logic [15:0] cmp2_ff;
   logic [15:0] cap1_ff;
   logic [15:0] cap2_ff;
   logic [4:0]  flg_ff;
   logic [4:0]  arm_ff;
   logic        cmp1Inh_ff;
   logic        cmp2Inh_ff;
   logic        cap1Hold_ff;
   logic        cap2Hold_ff;
   logic [2:0]  div_ff;
   logic        pin1_ff;
   logic        pin2_ff;
   logic        irq_ff;
   logic [31:0] rdat_ff;
   logic [NUM_PINS-1:0] pinRise;
   logic [NUM_PINS-1:0] pinFall;
   logic [NUM_PINS-1:0] pinVec;
   logic [5:0]  idx;
   logic        mapped;
   logic        acc;
   logic        wrAcc;
   logic        rdAcc;
   logic [7:0]  rdMux;
   logic [7:0]  wd;
   logic [2:0]  divLim;
   logic        tick;
   logic        pwmOn;
   logic        onepOn;
   logic        cap1Edge;
   logic        cap2Edge;
   logic        match1;
   logic        match2;
   logic        cntLoad;
   logic        ovfEvt;
   logic [4:0]  flgSet;
   logic [4:0]  lowAcc;
   logic [4:0]  flgClr;
   logic        frc1;
   logic        frc2;

   // Pin synchronisers
   assign pinVec = {capturePinTwo, capturePinOne, extClockPin};
   generate
      for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
         pin_sync_edge u_sync (
            .mclk     (mclk),
            .arst_n   (arst_n),
            .pinIn    (pinVec[g]),
            .riseEdge (pinRise[g]),
            .fallEdge (pinFall[g])
         );
      end
   endgenerate

   // Bus decode
   assign idx    = paddr[7:2];
   assign mapped = (idx >= IDX_CTL2) && (idx <= IDX_CMP2L);
   assign acc    = psel & penable;
   assign wrAcc  = acc & pwrite & mapped;
   assign rdAcc  = acc & ~pwrite & mapped;
   assign wd     = pwdata[7:0];
   assign pready = psel & penable;
   assign pslverr = acc & ~mapped;
   assign prdata = rdat_ff;

   always_comb begin
      rdMux = 8'h00;
      unique case (idx)
         IDX_CTL2:  rdMux = ctl2_ff;
         IDX_CTL1:  rdMux = ctl1_ff;
         IDX_STAT:  rdMux = {flg_ff, 3'h0};
         IDX_CAP1H: rdMux = cap1_ff[15:8];
         IDX_CAP1L: rdMux = cap1_ff[7:0];
         IDX_CMP1H: rdMux = cmp1_ff[15:8];
         IDX_CMP1L: rdMux = cmp1_ff[7:0];
         IDX_CNTH:  rdMux = cnt_ff[15:8];
         IDX_CNTL:  rdMux = cnt_ff[7:0];
         IDX_ACNTH: rdMux = cnt_ff[15:8];
         IDX_ACNTL: rdMux = cnt_ff[7:0];
         IDX_CAP2H: rdMux = cap2_ff[15:8];
         IDX_CAP2L: rdMux = cap2_ff[7:0];
         IDX_CMP2H: rdMux = cmp2_ff[15:8];
         IDX_CMP2L: rdMux = cmp2_ff[7:0];
         default:   rdMux = 8'h00;
      endcase
   end

   // Read data latched in the setup cycle
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdat_ff <= 32'h0000_0000;
      end else if (psel && !penable) begin
         rdat_ff <= {24'h00_0000, (pwrite ? 8'h00 : rdMux)};
      end
   end

   // Control registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctl1_ff <= CTL_RST;
         ctl2_ff <= CTL_RST;
      end else if (wrAcc) begin
         if (idx == IDX_CTL1) begin
            ctl1_ff <= wd;
         end
         if (idx == IDX_CTL2) begin
            ctl2_ff <= wd;
         end
      end
   end

   assign pwmOn  = ctl2_ff[B_MOD];
   assign onepOn = ctl2_ff[B_ONEP] & ~ctl2_ff[B_MOD];
   assign outputEnableOne = ctl2_ff[B_OEN1];
   assign outputEnableTwo = ctl2_ff[B_OEN2];

   // Timer tick from prescaler or external edge
   always_comb begin
      unique case (ctl2_ff[B_CSELH:B_CSELL])
         CSEL_DIV4: divLim = LIM_DIV4;
         CSEL_DIV2: divLim = LIM_DIV2;
         CSEL_DIV8: divLim = LIM_DIV8;
         CSEL_EXT:  divLim = LIM_DIV8;
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         div_ff <= 3'h0;
      end else if (cntLoad || (div_ff >= divLim)) begin
         // Prescaler restarts with the counter: a loaded value lasts a tick
         div_ff <= 3'h0;
      end else begin
         div_ff <= div_ff + 3'h1;
      end
   end

   assign tick = (ctl2_ff[B_CSELH:B_CSELL] == CSEL_EXT) ?
                 (ctl2_ff[B_EXEDGE] ? pinRise[PIN_EXT]
                                    : pinFall[PIN_EXT])
                 : (div_ff >= divLim);

   // Capture edges
   assign cap1Edge = ctl1_ff[B_EDGE1] ? pinRise[PIN_CAP1]
                                      : pinFall[PIN_CAP1];
   assign cap2Edge = ctl2_ff[B_EDGE2] ? pinRise[PIN_CAP2]
                                      : pinFall[PIN_CAP2];

   // Compare matches on each tick
   assign match1 = tick & (cnt_ff == cmp1_ff) & ~cmp1Inh_ff;
   assign match2 = tick & (cnt_ff == cmp2_ff) & ~cmp2Inh_ff;

   // Free-running counter
   assign cntLoad = (wrAcc && (idx == IDX_CNTL || idx == IDX_ACNTL))
                  || (onepOn && cap1Edge)
                  || (pwmOn && match2);
   assign ovfEvt = tick & ~cntLoad & (cnt_ff == CNT_TOP);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff <= CNT_START;
      end else if (cntLoad) begin
         cnt_ff <= CNT_START;
      end else if (tick) begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end

   // Compare values, high byte write inhibits compare
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmp1_ff    <= CMP_RST;
         cmp2_ff    <= CMP_RST;
         cmp1Inh_ff <= 1'b0;
         cmp2Inh_ff <= 1'b0;
      end else if (wrAcc) begin
         unique case (idx)
            IDX_CMP1H: begin
               cmp1_ff[15:8] <= wd;
               cmp1Inh_ff    <= 1'b1;
            end
            IDX_CMP1L: begin
               cmp1_ff[7:0] <= wd;
               cmp1Inh_ff   <= 1'b0;
            end
            IDX_CMP2H: begin
               cmp2_ff[15:8] <= wd;
               cmp2Inh_ff    <= 1'b1;
            end
            IDX_CMP2L: begin
               cmp2_ff[7:0] <= wd;
               cmp2Inh_ff   <= 1'b0;
            end
            default: begin
            end
         endcase
      end
   end

   // Capture registers, high byte read holds until low byte read
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cap1_ff     <= 16'h0000;
         cap2_ff     <= 16'h0000;
         cap1Hold_ff <= 1'b0;
         cap2Hold_ff <= 1'b0;
      end else begin
         if (onepOn && cap1Edge) begin
            cap1_ff <= CAP_ONEP;
         end else if (!pwmOn && cap1Edge && !cap1Hold_ff) begin
            cap1_ff <= cnt_ff;
         end
         if (cap2Edge && !cap2Hold_ff) begin
            cap2_ff <= cnt_ff;
         end
         if (rdAcc && idx == IDX_CAP1H) begin
            cap1Hold_ff <= 1'b1;
         end else if (rdAcc && idx == IDX_CAP1L) begin
            cap1Hold_ff <= 1'b0;
         end
         if (rdAcc && idx == IDX_CAP2H) begin
            cap2Hold_ff <= 1'b1;
         end else if (rdAcc && idx == IDX_CAP2L) begin
            cap2Hold_ff <= 1'b0;
         end
      end
   end

   // Status flags: set wins over clear
   assign flgSet[F_CAP1] = (cap1Edge & ~pwmOn)
                         | (pwmOn & match2);
   assign flgSet[F_CMP1] = match1 & ~pwmOn & ~onepOn;
   assign flgSet[F_OVF]  = ovfEvt;
   assign flgSet[F_CAP2] = cap2Edge;
   assign flgSet[F_CMP2] = match2 & ~pwmOn;

   assign lowAcc[F_CAP1] = acc & mapped & (idx == IDX_CAP1L);
   assign lowAcc[F_CMP1] = acc & mapped & (idx == IDX_CMP1L);
   assign lowAcc[F_OVF]  = acc & mapped & (idx == IDX_CNTL);
   assign lowAcc[F_CAP2] = acc & mapped & (idx == IDX_CAP2L);
   assign lowAcc[F_CMP2] = acc & mapped & (idx == IDX_CMP2L);
   assign flgClr = arm_ff & lowAcc;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         flg_ff <= 5'h00;
      end else begin
         flg_ff <= (flg_ff & ~flgClr) | flgSet;
      end
   end

   // Arm from the value software saw in the status read
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         arm_ff <= 5'h00;
      end else if (rdAcc && idx == IDX_STAT) begin
         arm_ff <= rdat_ff[7:3];
      end else begin
         arm_ff <= arm_ff & ~flgClr;
      end
   end

   // Output pins
   assign frc1 = wrAcc & (idx == IDX_CTL1) & wd[B_FORCE1] & ~pwmOn & ~onepOn;
   assign frc2 = wrAcc & (idx == IDX_CTL1) & wd[B_FORCE2] & ~pwmOn & ~onepOn;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pin1_ff <= 1'b0;
      end else if (frc1) begin
         pin1_ff <= wd[B_LVL1];
      end else if (pwmOn) begin
         if (match2) begin
            pin1_ff <= ctl1_ff[B_LVL2];
         end else if (match1) begin
            pin1_ff <= ctl1_ff[B_LVL1];
         end
      end else if (onepOn) begin
         if (cap1Edge) begin
            pin1_ff <= ctl1_ff[B_LVL2];
         end else if (match1) begin
            pin1_ff <= ctl1_ff[B_LVL1];
         end
      end else if (match1) begin
         pin1_ff <= ctl1_ff[B_LVL1];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pin2_ff <= 1'b0;
      end else if (frc2) begin
         pin2_ff <= wd[B_LVL2];
      end else if (match2 && !pwmOn && !onepOn) begin
         pin2_ff <= ctl1_ff[B_LVL2];
      end
   end

   assign outputPinOne = pin1_ff;
   assign outputPinTwo = pin2_ff;

   // Interrupt request
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= (ctl1_ff[B_CAPIE] & (flg_ff[F_CAP1] | flg_ff[F_CAP2]))
                 | (ctl1_ff[B_CMPIE] & (flg_ff[F_CMP1] | flg_ff[F_CMP2]))
                 | (ctl1_ff[B_OVFIE] & flg_ff[F_OVF]);
      end
   end

   assign timerIrq = irq_ff;

   // Checks
   periodReload_a:
      assert property (@(posedge mclk) disable iff (!arst_n)
         pwmOn && match2 |=> cnt_ff == CNT_START)
      else $error("counter not reloaded at period match");

   noCmpFlag_a:
      assert property (@(posedge mclk) disable iff (!arst_n)
         pwmOn && $past(pwmOn) |-> !$rose(flg_ff[F_CMP1])
                                   && !$rose(flg_ff[F_CMP2]))
      else $error("compare flag set in PWM mode");

   periodCapFlag_a:
      assert property (@(posedge mclk) disable iff (!arst_n)
         pwmOn && match2 |=> flg_ff[F_CAP1])
      else $error("capture flag one not set at period match");

   ovfRoll_a:
      assert property (@(posedge mclk) disable iff (!arst_n)
         $rose(flg_ff[F_OVF]) |-> $past(cnt_ff) == CNT_TOP
                                  && cnt_ff == 16'h0000)
      else $error("overflow flag without rollover");

   cmpInhibit_a:
      assert property (@(posedge mclk) disable iff (!arst_n)
         wrAcc && idx == IDX_CMP1H ##1 (!wrAcc || idx != IDX_CMP1L) [*2]
         |-> !$rose(flg_ff[F_CMP1]) && !match1)
      else $error("compare one ran while inhibited");

   pwmLevel_a:
      assert property (@(posedge mclk) disable iff (!arst_n)
         pwmOn && match1 && !match2 |=>
            outputPinOne == $past(ctl1_ff[B_LVL1]))
      else $error("pin one not at level one after match");

   forcePin_a:
      assert property (@(posedge mclk) disable iff (!arst_n)
         frc1 |=> outputPinOne == $past(wd[B_LVL1]))
      else $error("forced level not on pin one");

   irqOvf_a:
      assert property (@(posedge mclk) disable iff (!arst_n)
         ctl1_ff[B_OVFIE] && flg_ff[F_OVF] |=> timerIrq)
      else $error("overflow interrupt missing");

   flagClear_a:
      assert property (@(posedge mclk) disable iff (!arst_n)
         $fell(flg_ff[F_CAP1]) |-> $past(arm_ff[F_CAP1])
                                   && $past(lowAcc[F_CAP1]))
      else $error("capture flag one cleared without sequence");
endmodule

// ---- logic/timer_pkg.sv ----
// Purpose: Shared constants for the capture/compare timer
// Assumes: APB word per register, byte address is four times the index
// Notes:   Counter and compare reset values are fixed by the hardware
package timer_pkg;
   // Register indices
   localparam logic [5:0] IDX_CTL2  = 6'h31;
   localparam logic [5:0] IDX_CTL1  = 6'h32;
   localparam logic [5:0] IDX_STAT  = 6'h33;
   localparam logic [5:0] IDX_CAP1H = 6'h34;
   localparam logic [5:0] IDX_CAP1L = 6'h35;
   localparam logic [5:0] IDX_CMP1H = 6'h36;
   localparam logic [5:0] IDX_CMP1L = 6'h37;
   localparam logic [5:0] IDX_CNTH  = 6'h38;
   localparam logic [5:0] IDX_CNTL  = 6'h39;
   localparam logic [5:0] IDX_ACNTH = 6'h3A;
   localparam logic [5:0] IDX_ACNTL = 6'h3B;
   localparam logic [5:0] IDX_CAP2H = 6'h3C;
   localparam logic [5:0] IDX_CAP2L = 6'h3D;
   localparam logic [5:0] IDX_CMP2H = 6'h3E;
   localparam logic [5:0] IDX_CMP2L = 6'h3F;
   // Control 1 fields
   localparam int B_CAPIE  = 7;
   localparam int B_CMPIE  = 6;
   localparam int B_OVFIE  = 5;
   localparam int B_FORCE2 = 4;
   localparam int B_FORCE1 = 3;
   localparam int B_LVL2   = 2;
   localparam int B_EDGE1  = 1;
   localparam int B_LVL1   = 0;
   // Control 2 fields
   localparam int B_OEN1   = 7;
   localparam int B_OEN2   = 6;
   localparam int B_ONEP   = 5;
   localparam int B_MOD    = 4;
   localparam int B_CSELH  = 3;
   localparam int B_CSELL  = 2;
   localparam int B_EDGE2  = 1;
   localparam int B_EXEDGE = 0;
   // Flag vector positions, status bit = position + 3
   localparam int F_CAP1 = 4;
   localparam int F_CMP1 = 3;
   localparam int F_OVF  = 2;
   localparam int F_CAP2 = 1;
   localparam int F_CMP2 = 0;
   // Clock select codes and divider limits
   localparam logic [1:0] CSEL_DIV4 = 2'h0;
   localparam logic [1:0] CSEL_DIV2 = 2'h1;
   localparam logic [1:0] CSEL_DIV8 = 2'h2;
   localparam logic [1:0] CSEL_EXT  = 2'h3;
   localparam logic [2:0] LIM_DIV4  = 3'h3;
   localparam logic [2:0] LIM_DIV2  = 3'h1;
   localparam logic [2:0] LIM_DIV8  = 3'h7;
   // Reset and load values
   localparam logic [7:0]  CTL_RST   = 8'h00;
   localparam logic [15:0] CMP_RST   = 16'h8000;
   localparam logic [15:0] CNT_START = 16'hFFFC;
   localparam logic [15:0] CNT_TOP   = 16'hFFFF;
   localparam logic [15:0] CAP_ONEP  = 16'hFFFD;
   localparam int          NUM_PINS  = 3;
   localparam int          PIN_EXT   = 0;
   localparam int          PIN_CAP1  = 1;
   localparam int          PIN_CAP2  = 2;
endpackage

// ---- logic/pin_sync_edge.sv ----
// Purpose: Two-stage synchroniser with edge pulses for one pin
// Assumes: Pin is asynchronous to mclk
// Notes:   Edge pulses last one mclk cycle
`timescale 1ns/1ps
module pin_sync_edge (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic arst_n,
   // Pin and edges
   input  wire logic pinIn,
   output logic      riseEdge,
   output logic      fallEdge
);
   logic sync1_ff;
   logic sync2_ff;
   logic last_ff;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         last_ff  <= 1'b0;
      end else begin
         sync1_ff <= pinIn;
         sync2_ff <= sync1_ff;
         last_ff  <= sync2_ff;
      end
   end

   assign riseEdge = sync2_ff & ~last_ff;
   assign fallEdge = ~sync2_ff & last_ff;
endmodule

// ---- verif/timer_pins_model.sv ----
// Purpose: Pin-side model: external timer clock and both capture pins
// Assumes: Capture pins change just after a rising mclk edge
// Notes:   External clock runs free with a 60 ns period
`timescale 1ns/1ps
module timer_pins_model (
   // Clock
   input  wire logic mclk,
   // Pins toward the timer
   output logic      extClockPin,
   output logic      capturePinOne,
   output logic      capturePinTwo
);
   initial begin
      capturePinOne = 1'b0;
      capturePinTwo = 1'b0;
      extClockPin   = 1'b0;
      #3;
      forever #30 extClockPin = ~extClockPin;
   end

   // Set one capture pin, then give the timer time to see it
   task automatic drive(input int pin, input logic v);
      @(posedge mclk);
      if (pin == 1) begin
         capturePinOne <= v;
      end else begin
         capturePinTwo <= v;
      end
      repeat (8) @(posedge mclk);
   endtask
endmodule

// ---- verif/capture_compare_timer_pwm_test.sv ----
// Purpose: Self-checking bench for the capture/compare timer
// Assumes: Zero-wait APB slave, byte address is four times the index
// Notes:   PWM period is measured for every clock select
`timescale 1ns/1ps
module capture_compare_timer_pwm_test;
   import timer_pkg::*;
   logic        mclk, arst_n, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err, extClockPin, timerIrq;
   logic        capturePinOne, capturePinTwo, outputPinOne, outputPinTwo;
   logic        outputEnableOne, outputEnableTwo;
   int          errors, n_compared, hi, per;
   logic [7:0]  pwmCtl [5];
   int          pwmDiv [5];

   capture_compare_timer_pwm dut (.mclk(mclk), .arst_n(arst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .extClockPin(extClockPin),
      .capturePinOne(capturePinOne), .capturePinTwo(capturePinTwo),
      .outputPinOne(outputPinOne), .outputEnableOne(outputEnableOne),
      .outputPinTwo(outputPinTwo), .outputEnableTwo(outputEnableTwo),
      .timerIrq(timerIrq));
   timer_pins_model pins (.mclk(mclk), .extClockPin(extClockPin),
      .capturePinOne(capturePinOne), .capturePinTwo(capturePinTwo));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic test_done();
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer: setup, then access until pready
   task automatic bus(input logic w, input logic [5:0] idx,
                      input logic [7:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h0, d};
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rchk(input string nm, input logic [5:0] idx,
                       input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      chk(nm, rd, {24'h0, e});
   endtask

   // High time and period of compare pin one, in mclk cycles
   task automatic meas();
      int n;
      n = 0;
      while (outputPinOne !== 1'b0 && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      while (outputPinOne !== 1'b1 && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      hi = 0;
      while (outputPinOne === 1'b1 && hi < 3000) begin
         @(posedge mclk);
         hi++;
      end
      per = hi;
      while (outputPinOne === 1'b0 && per < 3000) begin
         @(posedge mclk);
         per++;
      end
   endtask

   initial begin
      repeat (60000) @(posedge mclk);
      errors++;
      test_done();
   end

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      arst_n = 1'b0;
      errors = 0;
      n_compared = 0;
      pwmCtl = '{8'hB4, 8'hB0, 8'hB8, 8'hBD, 8'hBC};
      pwmDiv = '{2, 4, 8, 6, 6};
      repeat (8) @(posedge mclk);
      arst_n <= 1'b1;
      rchk("ctl2 rst", IDX_CTL2, 8'h00);
      rchk("ctl1 rst", IDX_CTL1, 8'h00);
      rchk("stat rst", IDX_STAT, 8'h00);
      rchk("cmp1h rst", IDX_CMP1H, 8'h80);
      rchk("cmp1l rst", IDX_CMP1L, 8'h00);
      rchk("cmp2h rst", IDX_CMP2H, 8'h80);
      rchk("cmp2l rst", IDX_CMP2L, 8'h00);
      bus(1'b0, 6'h00, 8'h00);
      chk("slverr", {31'h0, err}, 32'h1);
      chk("unmapped", rd, 32'h0);
      wr(IDX_STAT, 8'hFF);
      // Counter has rolled over from its reset value by now
      rchk("stat ro", IDX_STAT, 8'h20);
      // Forced output levels
      wr(IDX_CTL2, 8'hC0);
      rchk("ctl2 rw", IDX_CTL2, 8'hC0);
      wr(IDX_CTL1, 8'h1D);
      repeat (2) @(posedge mclk);
      chk("force hi", {outputPinTwo, outputPinOne}, 32'h3);
      chk("oen", {outputEnableOne, outputEnableTwo}, 32'h3);
      wr(IDX_CTL1, 8'h05);
      repeat (2) @(posedge mclk);
      chk("no force", {outputPinTwo, outputPinOne}, 32'h3);
      wr(IDX_CTL1, 8'h18);
      repeat (2) @(posedge mclk);
      chk("force lo", {outputPinTwo, outputPinOne}, 32'h0);
      // Overflow flag and its clearing path
      wr(IDX_CTL2, 8'h04);
      wr(IDX_CTL1, 8'h20);
      wr(IDX_CNTL, 8'h00);
      repeat (20) @(posedge mclk);
      chk("ovf irq", {31'h0, timerIrq}, 32'h1);
      rchk("ovf", IDX_STAT, 8'h20);
      bus(1'b0, IDX_ACNTL, 8'h00);
      rchk("ovf alt", IDX_STAT, 8'h20);
      bus(1'b0, IDX_CNTL, 8'h00);
      rchk("ovf clr", IDX_STAT, 8'h00);
      chk("ovf irq clr", {31'h0, timerIrq}, 32'h0);
      // Compare one with high-byte inhibit
      wr(IDX_CTL1, 8'h41);
      wr(IDX_CTL2, 8'h84);
      wr(IDX_CMP1H, 8'h00);
      wr(IDX_CNTL, 8'h00);
      repeat (40) @(posedge mclk);
      rchk("inhibit", IDX_STAT, 8'h20);
      chk("inhibit pin", {31'h0, outputPinOne}, 32'h0);
      wr(IDX_CMP1L, 8'h20);
      wr(IDX_CNTL, 8'h00);
      repeat (90) @(posedge mclk);
      rchk("cmp1", IDX_STAT, 8'h60);
      chk("cmp1 pin", {31'h0, outputPinOne}, 32'h1);
      chk("cmp irq", {31'h0, timerIrq}, 32'h1);
      wr(IDX_CMP1L, 8'h20);
      rchk("cmp1 clr", IDX_STAT, 8'h20);
      chk("cmp irq clr", {31'h0, timerIrq}, 32'h0);
      bus(1'b0, IDX_CNTL, 8'h00);
      // Capture two, both edge polarities
      wr(IDX_CTL1, 8'h80);
      for (int e = 0; e < 2; e++) begin
         wr(IDX_CTL2, {6'h01, e[0], 1'b0});
         pins.drive(2, e[0]);
         bus(1'b0, IDX_STAT, 8'h00);
         bus(1'b0, IDX_CAP2L, 8'h00);
         pins.drive(2, !e[0]);
         rchk("cap2 wrong edge", IDX_STAT, 8'h00);
         pins.drive(2, e[0]);
         rchk("cap2", IDX_STAT, 8'h10);
         chk("cap irq", {31'h0, timerIrq}, 32'h1);
         bus(1'b0, IDX_CAP2L, 8'h00);
         rchk("cap2 clr", IDX_STAT, 8'h00);
         chk("cap irq clr", {31'h0, timerIrq}, 32'h0);
      end
      // PWM with one-pulse also set, every clock select
      wr(IDX_CTL1, 8'h04);
      wr(IDX_CTL2, 8'hB4);
      wr(IDX_CMP2H, 8'h00);
      wr(IDX_CMP2L, 8'h10);
      wr(IDX_CMP1H, 8'h00);
      wr(IDX_CMP1L, 8'h08);
      wr(IDX_CNTL, 8'h00);
      for (int i = 0; i < 5; i++) begin
         wr(IDX_CTL2, pwmCtl[i]);
         meas();
         chk("pwm high", hi, (8 + 5) * pwmDiv[i]);
         chk("pwm period", per, (16 + 5) * pwmDiv[i]);
      end
      rchk("pwm flags", IDX_STAT, 8'hA0);
      pins.drive(2, 1'b0);
      rchk("pwm cap2", IDX_STAT, 8'hB0);
      // One pulse from a falling edge on capture pin one
      wr(IDX_CTL2, 8'h84);
      chk("oen1 only", {outputEnableOne, outputEnableTwo}, 32'h2);
      wr(IDX_CTL1, 8'h08);
      wr(IDX_CTL1, 8'h04);
      wr(IDX_CTL2, 8'hA4);
      fork
         meas();
         begin
            pins.drive(1, 1'b1);
            pins.drive(1, 1'b0);
         end
      join
      chk("pulse", hi, (8 + 5) * 2);
      test_done();
   end
endmodule
